// ==== design/hrh_pkg.sv ====
/*
 Shared constants for the host port ready handshake.
 Assumes a single 200 MHz core clock standing in for the peripheral clock.
*/
//----------------------------------------------------------------------
// Notes on behaviour
//----------------------------------------------------------------------
// Notes on behaviour
// - Combined strobe active when chip select low and the two data strobes differ.
// - Address write after address write or read command may drive ready not-ready.
// - Data write while write FIFO full, flushing or not empty may stall.
// - Any other host write keeps ready low throughout.
// - Auto-increment data read missing in read FIFO may stall, first half only.
// - First half of data read without auto-increment may stall while fetching.
// - Auto-increment data read with data present keeps ready low both halves.
// - Second half of non-increment data read never stalls.
// - Control and address register reads never stall.
// - Read data is valid on the bus no later than ready going low.
// - Ready is driven low whenever chip select is released.
package hrh_pkg;
    // Access type from the two access-control lines
    typedef enum logic [1:0] {
        HRH_ACC_CTRL = 2'b00,
        HRH_ACC_DATA_INC = 2'b01,
        HRH_ACC_ADDR = 2'b10,
        HRH_ACC_DATA = 2'b11
    } hrh_acc_t;

    typedef enum logic [1:0] {
        HRH_IDLE = 2'b00,
        HRH_STALL = 2'b01,
        HRH_READY = 2'b10,
        HRH_GAP = 2'b11
    } hrh_state_t;

    localparam logic HRH_RDY_RST = 1'b0;
    localparam int HRH_CLK_PERIOD_NS = 5;
    localparam int HRH_GAP_PERIODS = 2;
    localparam logic [1:0] HRH_GAP_CYCLES = 2'(HRH_GAP_PERIODS);
    localparam logic [15:0] HRH_DATA_RST = 16'h0000;
endpackage : hrh_pkg

// ==== design/hrh_host_port.sv ====
/*
 Ready handshake of a multiplexed 16-bit host port.
 Assumes host pins are asynchronous and the internal side answers on core_clk.
*/
`timescale 1ns/100ps
module hrh_host_port
    import hrh_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic host_chip_select_n,
    input wire logic data_strobe_a_n,
    input wire logic data_strobe_b_n,
    input wire logic access_control_a,
    input wire logic access_control_b,
    input wire logic host_read_not_write,
    input wire logic half_word_select,
    input wire logic [15:0] host_data_in,
    output logic [15:0] host_data_out,
    output logic host_data_oe,
    output logic host_ready_n,
    input wire logic addr_follow_cmd,
    input wire logic write_fifo_busy,
    input wire logic read_fifo_hit,
    input wire logic [15:0] reg_read_data,
    input wire logic reg_read_valid,
    output logic access_start,
    output logic [1:0] access_type,
    output logic access_read,
    output logic access_half,
    output logic [15:0] access_wdata
);
    //------------------------------------------------------------------
    // Input synchronisers
    //------------------------------------------------------------------
    logic [6:0] meta_q, sync_q;
    logic [15:0] dataMeta_q, dataSync_q;
    // Two-flop synchronisers for all pins
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            meta_q <= 7'h7F;
            sync_q <= 7'h7F;
            dataMeta_q <= HRH_DATA_RST;
            dataSync_q <= HRH_DATA_RST;
        end else begin
            meta_q <= {host_chip_select_n, data_strobe_a_n, data_strobe_b_n, access_control_a,
                       access_control_b, host_read_not_write, half_word_select};
            sync_q <= meta_q;
            dataMeta_q <= host_data_in;
            dataSync_q <= dataMeta_q;
        end
    end

    logic csN, strobeN;
    assign csN = sync_q[6];
    assign strobeN = ~(sync_q[5] ^ sync_q[4]) | csN;

    //------------------------------------------------------------------
    // Synchronised select lines
    //------------------------------------------------------------------
    logic [1:0] selType;
    logic selRead, selHalf;
    // Select lines as the handshake sees them at capture
    assign selType = sync_q[3:2];
    assign selRead = sync_q[1];
    assign selHalf = sync_q[0];

    // True for either data register access, with or without increment
    function automatic logic is_data_acc(input logic [1:0] accKind);
        return accKind == HRH_ACC_DATA || accKind == HRH_ACC_DATA_INC;
    endfunction : is_data_acc

    //------------------------------------------------------------------
    // Handshake state machine
    //------------------------------------------------------------------
    hrh_state_t state_q, state_d;
    logic rdyN_q, rdyN_d, oe_q, oe_d, start_q, start_d;
    logic [1:0] type_q, type_d, gap_q, gap_d;
    logic read_q, read_d, half_q, half_d, lastAddrW_q, lastAddrW_d;
    logic [15:0] rdata_q, rdata_d, wdata_q, wdata_d;
    logic stall;

    // Stall decision for the access just captured
    always_comb begin
        stall = 1'b0;
        if (!read_d) begin
            if (type_d == HRH_ACC_ADDR)
                stall = lastAddrW_q | addr_follow_cmd;
            else if (is_data_acc(type_d))
                stall = write_fifo_busy;
            else
                stall = 1'b0;
        end else if (type_d == HRH_ACC_DATA_INC) begin
            stall = !half_d && !read_fifo_hit;
        end else if (type_d == HRH_ACC_DATA) begin
            stall = !half_d;
        end else begin
            stall = 1'b0;
        end
    end

    // Next state and outputs
    always_comb begin
        state_d = state_q;
        rdyN_d = rdyN_q;
        oe_d = oe_q;
        start_d = 1'b0;
        type_d = type_q;
        gap_d = gap_q;
        read_d = read_q;
        half_d = half_q;
        lastAddrW_d = lastAddrW_q;
        rdata_d = rdata_q;
        wdata_d = wdata_q;
        case (state_q)
            HRH_IDLE: begin
                rdyN_d = 1'b0;
                if (!strobeN) begin
                    type_d = {sync_q[3], sync_q[2]};
                    read_d = sync_q[1];
                    half_d = sync_q[0];
                    wdata_d = dataSync_q;
                    start_d = 1'b1;
                    oe_d = sync_q[1];
                    if (stall) begin
                        rdyN_d = 1'b1;
                        state_d = HRH_STALL;
                    end else begin
                        rdata_d = reg_read_data;
                        state_d = HRH_READY;
                    end
                end
            end
            HRH_STALL: begin
                // Ready low once read data is valid or the write FIFO is free; a deselect lowers it at once
                if (read_q ? reg_read_valid : !write_fifo_busy) begin
                    rdata_d = reg_read_data;
                    rdyN_d = 1'b0;
                    state_d = HRH_READY;
                end
            end
            HRH_READY: begin
                if (strobeN) begin
                    oe_d = 1'b0;
                    lastAddrW_d = !read_q && type_q == HRH_ACC_ADDR;
                    gap_d = HRH_GAP_CYCLES - 2'd1;
                    state_d = HRH_GAP;
                end
            end
            HRH_GAP: begin
                // Hold off a new access for the minimum gap
                if (gap_q != 2'd0)
                    gap_d = gap_q - 2'd1;
                else
                    state_d = HRH_IDLE;
            end
            default: state_d = HRH_IDLE;
        endcase
        if (csN) begin
            rdyN_d = 1'b0;
            oe_d = 1'b0;
            if (state_q == HRH_STALL)
                state_d = HRH_IDLE;
        end
    end

    // State registers
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_q <= HRH_IDLE;
            rdyN_q <= HRH_RDY_RST;
            oe_q <= 1'b0;
            start_q <= 1'b0;
            type_q <= HRH_ACC_CTRL;
            gap_q <= 2'd0;
            read_q <= 1'b0;
            half_q <= 1'b0;
            lastAddrW_q <= 1'b0;
            rdata_q <= HRH_DATA_RST;
            wdata_q <= HRH_DATA_RST;
        end else begin
            state_q <= state_d;
            rdyN_q <= rdyN_d;
            oe_q <= oe_d;
            start_q <= start_d;
            type_q <= type_d;
            gap_q <= gap_d;
            read_q <= read_d;
            half_q <= half_d;
            lastAddrW_q <= lastAddrW_d;
            rdata_q <= rdata_d;
            wdata_q <= wdata_d;
        end
    end

    assign host_ready_n = rdyN_q;
    assign host_data_oe = oe_q;
    assign host_data_out = rdata_q;
    assign access_start = start_q;
    assign access_type = type_q;
    assign access_read = read_q;
    assign access_half = half_q;
    assign access_wdata = wdata_q;

    //------------------------------------------------------------------
    // Assertions
    //------------------------------------------------------------------
    // Chip select seen high by the handshake
    sequence sDeselect;
        csN;
    endsequence

    // An access is taken on this edge
    sequence sCapture;
        state_q == HRH_IDLE && !strobeN;
    endsequence

    // Two cycles of idle gap after the strobe is released
    sequence sGapTwo;
        (state_q == HRH_GAP) ##1 (state_q == HRH_GAP);
    endsequence

    // Deselect always brings ready low
    a_ready_on_deselect: assert property (@(posedge core_clk) disable iff (sys_rst)
        sDeselect |=> !host_ready_n)
        else $error("ready not low after deselect");

    // Control register reads answer at once
    a_ctrl_read_nostall: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state_q == HRH_IDLE && !strobeN && sync_q[1] && !sync_q[3] && !sync_q[2])
        |=> !host_ready_n)
        else $error("control read stalled");

    // Control register writes answer at once
    a_write_plain: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state_q == HRH_IDLE && !strobeN && !sync_q[1] && !sync_q[3] && !sync_q[2])
        |=> !host_ready_n)
        else $error("plain write stalled");

    // Second half of a plain data read never waits
    a_second_half: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state_q == HRH_IDLE && !strobeN && sync_q[1] && sync_q[3] && sync_q[2] && sync_q[0])
        |=> !host_ready_n)
        else $error("second half read stalled");

    // First half of a plain data read fetches first
    a_first_half: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state_q == HRH_IDLE && !strobeN && !csN && sync_q[1] && sync_q[3] && sync_q[2] && !sync_q[0])
        |=> host_ready_n)
        else $error("first half read did not fetch");

    // Read data is loaded on the edge that lowers ready, aborts excluded
    a_read_data: assert property (@(posedge core_clk) disable iff (sys_rst)
        ($fell(host_ready_n) && read_q && !$past(csN)) |-> (host_data_out == $past(reg_read_data)))
        else $error("read data late");

    // Incrementing read with data present answers at once
    a_inc_hit: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state_q == HRH_IDLE && !strobeN && sync_q[1] && !sync_q[3] && sync_q[2] && read_fifo_hit)
        |=> !host_ready_n)
        else $error("incrementing hit stalled");

    // Released strobe is followed by the full idle gap
    a_gap_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state_q == HRH_READY && strobeN && !csN) |=> sGapTwo)
        else $error("gap too short");

    // Repeated address write, or one after a read command, waits
    a_addr_repeat: assert property (@(posedge core_clk) disable iff (sys_rst)
        sCapture ##0 (!selRead && selType == HRH_ACC_ADDR && (lastAddrW_q || addr_follow_cmd))
        |=> host_ready_n)
        else $error("address write did not stall");

    // Data write into a busy write FIFO waits
    a_write_busy: assert property (@(posedge core_clk) disable iff (sys_rst)
        sCapture ##0 (!selRead && is_data_acc(selType) && write_fifo_busy)
        |=> host_ready_n)
        else $error("busy data write did not stall");

    // Data write into an idle write FIFO answers at once
    a_write_free: assert property (@(posedge core_clk) disable iff (sys_rst)
        sCapture ##0 (!selRead && is_data_acc(selType) && !write_fifo_busy)
        |=> !host_ready_n)
        else $error("free data write stalled");

    // Incrementing first-half read with data missing waits
    a_inc_miss: assert property (@(posedge core_clk) disable iff (sys_rst)
        sCapture ##0 (selRead && selType == HRH_ACC_DATA_INC && !selHalf && !read_fifo_hit)
        |=> host_ready_n)
        else $error("incrementing miss did not stall");

    // Address register reads answer at once
    a_addr_read: assert property (@(posedge core_clk) disable iff (sys_rst)
        sCapture ##0 (selRead && selType == HRH_ACC_ADDR)
        |=> !host_ready_n)
        else $error("address read stalled");

    // Ready stays low while the host still holds the strobe
    a_ready_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state_q == HRH_READY && !strobeN) |=> !host_ready_n)
        else $error("ready rose during access");

    // Capture publishes the select lines with a start pulse
    a_capture_start: assert property (@(posedge core_clk) disable iff (sys_rst)
        sCapture |=> (access_start && access_type == $past(selType) && access_read == $past(selRead)
                      && access_half == $past(selHalf)))
        else $error("select lines not captured");

    // Start is a single-cycle pulse
    a_start_single: assert property (@(posedge core_clk) disable iff (sys_rst)
        access_start |=> !access_start)
        else $error("start pulse too long");

    // The data bus is driven only for reads
    a_oe_read: assert property (@(posedge core_clk) disable iff (sys_rst)
        host_data_oe |-> access_read)
        else $error("data bus driven on a write");
endmodule : hrh_host_port

// ==== tb/hrh_host_model.sv ====
/*
 Host processor model for the host port: drives select lines, strobes, write data.
 Assumes a 200 MHz core_clk; pins change on the falling edge.
*/
`timescale 1ns/100ps
module hrh_host_model (
    input wire logic core_clk,
    input wire logic host_ready_n,
    output logic host_chip_select_n,
    output logic data_strobe_a_n,
    output logic data_strobe_b_n,
    output logic access_control_a,
    output logic access_control_b,
    output logic host_read_not_write,
    output logic half_word_select,
    output logic [15:0] host_data_in
);
    initial {host_chip_select_n, data_strobe_a_n, data_strobe_b_n} = 3'h7;
    initial {access_control_a, access_control_b, host_read_not_write, half_word_select} = 4'h0;
    initial host_data_in = 16'h0000;
    // Present selects and open the strobe with one data strobe only
    task automatic begin_acc(input logic [1:0] typ, input logic rnw, input logic hw, input logic [15:0] wd);
        @(negedge core_clk);
        {access_control_a, access_control_b, host_read_not_write, half_word_select} = {typ, rnw, hw};
        host_data_in = wd;
        host_chip_select_n = 1'b0;
        data_strobe_a_n = 1'b0;
    endtask : begin_acc
    // Close the strobe, invert the data, then keep the idle gap
    task automatic end_acc();
        host_chip_select_n = 1'b1;
        data_strobe_a_n = 1'b1;
        host_data_in = ~host_data_in;
        repeat (5) @(negedge core_clk);
    endtask : end_acc
    // Drive chip select and the second data strobe directly
    task automatic set_pins(input logic csLevel, input logic stbB);
        host_chip_select_n = csLevel;
        data_strobe_b_n = stbB;
    endtask : set_pins
    // Full access: hold the strobe until ready is seen low
    task automatic access(input logic [1:0] typ, input logic rnw, input logic hw, input logic [15:0] wd,
                          output logic stalled);
        begin_acc(typ, rnw, hw, wd);
        stalled = 1'b0;
        repeat (3) @(negedge core_clk);
        for (int i = 0; i < 200 && host_ready_n !== 1'b0; i++) begin
            stalled = 1'b1;
            @(negedge core_clk);
        end
        if (host_ready_n !== 1'b0) stalled = 1'bx;
    endtask : access
endmodule : hrh_host_model

// ==== tb/tb_host_port_ready_handshake.sv ====
/*
 Self-checking bench for the host port ready handshake.
 Assumes the host model above and internal-side levels set by the bench per row; rdValid rises and wrBusy clears nine cycles after each row starts.
*/
`timescale 1ns/100ps
module tb_host_port_ready_handshake;
    import hrh_pkg::*;
    logic core_clk = 1'b0, sys_rst = 1'b1, stl, addrFollow = 1'b0, wrBusy = 1'b0, rdHit = 1'b0, rdValid = 1'b0;
    logic csN, stbA, stbB, ctlA, ctlB, rnw, half, readyN, dataOe, accStart, accRead, accHalf;
    logic [15:0] hostIn, hostOut, accWdata;
    logic [1:0] accType;
    logic [7:0] row;
    int fails = 0, tests_run = 0, starts = 0, s0;
    localparam logic [15:0] RD_DATA = 16'hA5C3;
    // Rows: type, read, half, follows command, fifo busy, read hit, stall expected
    localparam logic [7:0] ROWS [15] = '{8'h00, 8'h80, 8'h91, 8'h20, 8'h89, 8'hC5, 8'h55, 8'h40,
                                         8'h62, 8'h72, 8'h61, 8'h70, 8'hE1, 8'hF0, 8'hB0};
    initial forever #2.5 core_clk = ~core_clk;
    always @(negedge core_clk) if (accStart === 1'b1) starts++;
    hrh_host_model host (.core_clk(core_clk), .host_ready_n(readyN), .host_chip_select_n(csN),
        .data_strobe_a_n(stbA), .data_strobe_b_n(stbB), .access_control_a(ctlA), .access_control_b(ctlB),
        .host_read_not_write(rnw), .half_word_select(half), .host_data_in(hostIn));
    hrh_host_port uut (.core_clk(core_clk), .sys_rst(sys_rst), .host_chip_select_n(csN),
        .data_strobe_a_n(stbA), .data_strobe_b_n(stbB), .access_control_a(ctlA), .access_control_b(ctlB),
        .host_read_not_write(rnw), .half_word_select(half), .host_data_in(hostIn), .host_data_out(hostOut),
        .host_data_oe(dataOe), .host_ready_n(readyN), .addr_follow_cmd(addrFollow), .write_fifo_busy(wrBusy),
        .read_fifo_hit(rdHit), .reg_read_data(RD_DATA), .reg_read_valid(rdValid), .access_start(accStart),
        .access_type(accType), .access_read(accRead), .access_half(accHalf), .access_wdata(accWdata));
    // Compare one value against its expectation
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // Print the counts and the verdict, then stop
    task automatic test_done();
        $display("comparisons=%0d mismatches=%0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : test_done
    //------------------------------------------------------------------
    // Main sequence
    //------------------------------------------------------------------
    initial begin
        repeat (8) @(negedge core_clk);
        check({readyN, dataOe}, 16'h0000);
        sys_rst = 1'b0;
        repeat (3) @(negedge core_clk);
        foreach (ROWS[i]) begin
            row = ROWS[i];
            {addrFollow, wrBusy, rdHit} = row[3:1];
            s0 = starts;
            fork
                host.access(row[7:6], row[5], row[4], 16'h3C00 | 16'(i), stl);
                begin
                    repeat (9) @(negedge core_clk);
                    rdValid = 1'b1;
                    wrBusy = 1'b0;
                end
            join
            check({accType, accRead, accHalf, stl}, {11'h000, row[7:4], row[0]});
            if (row[5]) check({hostOut, dataOe}, {RD_DATA, 1'b1});
            else check(accWdata, 16'h3C00 | 16'(i));
            check(32'(starts - s0), 32'h0000_0001);
            host.end_acc();
            rdValid = 1'b0;
        end
        // Chip select released during a stalled read
        host.begin_acc(2'h3, 1'b1, 1'b0, 16'h0000);
        repeat (6) @(negedge core_clk);
        check(readyN, 1'b1);
        host.set_pins(1'b1, 1'b1);
        repeat (4) @(negedge core_clk);
        check(readyN, 1'b0);
        host.end_acc();
        // Both data strobes low together never form a strobe
        s0 = starts;
        host.begin_acc(2'h0, 1'b0, 1'b0, 16'h0000);
        host.set_pins(1'b0, 1'b0);
        repeat (8) @(negedge core_clk);
        check(16'(starts - s0), 16'h0000);
        host.set_pins(1'b0, 1'b1);
        host.end_acc();
        // Reset in the middle of a stalled read, then a clean access
        host.begin_acc(2'h3, 1'b1, 1'b0, 16'h0000);
        repeat (6) @(negedge core_clk);
        sys_rst = 1'b1;
        repeat (3) @(negedge core_clk);
        check({readyN, dataOe, accStart}, 16'h0000);
        host.end_acc();
        sys_rst = 1'b0;
        repeat (3) @(negedge core_clk);
        host.access(2'h0, 1'b1, 1'b0, 16'h0000, stl);
        check({hostOut, dataOe, stl}, {RD_DATA, 2'b10});
        host.end_acc();
        test_done();
    end
    // Watchdog
    initial begin
        #20000;
        fails++;
        test_done();
    end
endmodule : tb_host_port_ready_handshake
